// *** sosc_pkg.sv ***
package sosc_pkg;
  // ==========================================================
  // operating states
  typedef enum logic [2:0] {
    ST_OFF,
    ST_INIT,
    ST_RUN_DEEN,
    ST_RUN_EN,
    ST_ERROR
  } sosc_state_t;

  // ==========================================================
  // timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int PULSE_WIDTH_MS  = 2;
  localparam int PULSE_PERIOD_MS = 500;
  localparam int ECHO_DELAY_MS   = 40;
  localparam int INIT_TIME_US    = 100;
  localparam int PULSE_WIDTH_CYC  = (CLK_HZ / 1000) * PULSE_WIDTH_MS;
  localparam int PULSE_PERIOD_CYC = (CLK_HZ / 1000) * PULSE_PERIOD_MS;
  localparam int ECHO_DELAY_CYC   = (CLK_HZ / 1000) * ECHO_DELAY_MS;
  localparam int INIT_CYC         = (CLK_HZ / 1000000) * INIT_TIME_US;
  localparam int CNT_W            = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 24'h000001;

  // ==========================================================
  // positions of the field inputs in the synchroniser vector
  localparam int PIN_N      = 6;
  localparam int PIN_POWER  = 0;
  localparam int PIN_SUPPLY = 1;
  localparam int PIN_START  = 2;
  localparam int PIN_AUTO   = 3;
  localparam int PIN_DYN    = 4;
  localparam int PIN_STFAIL = 5;
endpackage : sosc_pkg

// *** sosc_top.sv ***
`timescale 1ns/100ps
module sosc_top #(
  parameter int PULSE_WIDTH_CYC  = sosc_pkg::PULSE_WIDTH_CYC,
  parameter int PULSE_PERIOD_CYC = sosc_pkg::PULSE_PERIOD_CYC,
  parameter int ECHO_DELAY_CYC   = sosc_pkg::ECHO_DELAY_CYC
) (
  // clock and reset (reset stands for device power-up)
  input  wire logic SYS_CLK,
  input  wire logic SRST,
  // device power present
  input  wire logic POWER_GOOD,
  // pins from the field
  input  wire logic SUPPLY_IN,
  input  wire logic START_AUTO_MANUAL_INPUT,
  // configuration: automatic start, both channels wired
  input  wire logic AUTO_START,
  input  wire logic DYN_WIRED,
  // self-test verdict
  input  wire logic SELF_TEST_FAIL,
  // outputs
  output logic      START_CONTROL_OUTPUT,
  output logic      OUTPUTS_ENERGIZED,
  output logic      SAFE_STATE,
  output logic      ERROR_FLAG
);

  // ==========================================================
  // constants at counter width
  localparam int CW = sosc_pkg::CNT_W;
  // pulse low time, counted from the start of each period
  localparam logic [CW-1:0] WIDTH_CNT   = CW'(PULSE_WIDTH_CYC);
  // last count of one pulse period
  localparam logic [CW-1:0] PERIOD_LAST = CW'(PULSE_PERIOD_CYC - 1);
  // last count of the echo window
  localparam logic [CW-1:0] ECHO_LAST   = CW'(ECHO_DELAY_CYC - 1);
  // last count of the self-test phase
  localparam logic [CW-1:0] INIT_LAST   = CW'(sosc_pkg::INIT_CYC - 1);

  // ==========================================================
  // declarations
  // raw field inputs gathered for the synchroniser loop
  logic [sosc_pkg::PIN_N-1:0] pin_raw;
  // first synchroniser stage, read by nothing but the second
  logic [sosc_pkg::PIN_N-1:0] sync1_q;
  // second synchroniser stage, the only one logic may read
  logic [sosc_pkg::PIN_N-1:0] sync2_q;
  // synchronised views of the inputs
  logic                       pg_s;
  logic                       supply_s;
  logic                       in_s;
  logic                       auto_s;
  logic                       dyn_s;
  logic                       stfail_s;
  // operating state
  sosc_pkg::sosc_state_t      state_q;
  sosc_pkg::sosc_state_t      state_d;
  // self-test duration counter
  logic [CW-1:0]              init_cnt_q;
  // test pulse period counter
  logic [CW-1:0]              per_cnt_q;
  // test pulsing allowed in this cycle
  logic                       pulse_en;
  // first cycle of a test pulse period
  logic                       pulse_start;
  // control output register
  logic                       ctl_q;
  // echo window open, its counter and the echo seen flag
  logic                       win_act_q;
  logic [CW-1:0]              win_cnt_q;
  logic                       seen_q;
  // window closed without an echo
  logic                       echo_miss;
  // manual start armed by a released button
  logic                       armed_q;
  // start/restart condition fulfilled
  logic                       start_ok;
  // registered outputs
  logic                       en_q;
  logic                       safe_q;
  logic                       err_q;

  // ==========================================================
  // input synchronisers
  assign pin_raw[sosc_pkg::PIN_POWER]  = POWER_GOOD;
  assign pin_raw[sosc_pkg::PIN_SUPPLY] = SUPPLY_IN;
  assign pin_raw[sosc_pkg::PIN_START]  = START_AUTO_MANUAL_INPUT;
  assign pin_raw[sosc_pkg::PIN_AUTO]   = AUTO_START;
  assign pin_raw[sosc_pkg::PIN_DYN]    = DYN_WIRED;
  assign pin_raw[sosc_pkg::PIN_STFAIL] = SELF_TEST_FAIL;

  // two flops per pin; field wiring is not on our clock
  genvar gi;
  generate
    for (gi = 0; gi < sosc_pkg::PIN_N; gi++) begin : g_sync
      always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  // synchronised names used by the rest of the block
  assign pg_s     = sync2_q[sosc_pkg::PIN_POWER];
  assign supply_s = sync2_q[sosc_pkg::PIN_SUPPLY];
  assign in_s     = sync2_q[sosc_pkg::PIN_START];
  assign auto_s   = sync2_q[sosc_pkg::PIN_AUTO];
  assign dyn_s    = sync2_q[sosc_pkg::PIN_DYN];
  assign stfail_s = sync2_q[sosc_pkg::PIN_STFAIL];

  // ==========================================================
  // self-test phase
  // self-test time count
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      init_cnt_q <= sosc_pkg::CNT_ZERO;
    end else if (state_q == sosc_pkg::ST_INIT) begin
      init_cnt_q <= init_cnt_q + sosc_pkg::CNT_ONE;
    end else begin
      init_cnt_q <= sosc_pkg::CNT_ZERO;
    end
  end

  // ==========================================================
  // test pulse generation
  // pulse only when both wired
  assign pulse_en = dyn_s && ((state_q == sosc_pkg::ST_RUN_DEEN) ||
                              (state_q == sosc_pkg::ST_RUN_EN));
  assign pulse_start = pulse_en && (per_cnt_q == sosc_pkg::CNT_ZERO);

  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      per_cnt_q <= sosc_pkg::CNT_ZERO;
    end else if (!pulse_en) begin
      // restart at zero so a new run begins with a pulse
      per_cnt_q <= sosc_pkg::CNT_ZERO;
    end else if (per_cnt_q == PERIOD_LAST) begin
      per_cnt_q <= sosc_pkg::CNT_ZERO;
    end else begin
      per_cnt_q <= per_cnt_q + sosc_pkg::CNT_ONE;
    end
  end

  // drive test pulses on control output
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ctl_q <= 1'b1;
    end else begin
      // high feeds the button; a pulse pulls it low
      ctl_q <= !(pulse_en && (per_cnt_q < WIDTH_CNT));
    end
  end

  // ==========================================================
  // echo window
  // accept echo inside window
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      win_act_q <= 1'b0;
      win_cnt_q <= sosc_pkg::CNT_ZERO;
      seen_q    <= 1'b0;
    end else if (!pulse_en) begin
      // pulsing stopped: no echo is owed
      win_act_q <= 1'b0;
      win_cnt_q <= sosc_pkg::CNT_ZERO;
      seen_q    <= 1'b0;
    end else if (pulse_start) begin
      win_act_q <= 1'b1;
      win_cnt_q <= sosc_pkg::CNT_ZERO;
      seen_q    <= 1'b0;
    end else if (win_act_q) begin
      // a low on the input channel is the echo
      if (!in_s) begin
        seen_q <= 1'b1;
      end
      if (win_cnt_q == ECHO_LAST) begin
        win_act_q <= 1'b0;
      end else begin
        win_cnt_q <= win_cnt_q + sosc_pkg::CNT_ONE;
      end
    end
  end

  assign echo_miss = win_act_q && (win_cnt_q == ECHO_LAST) &&
                     !seen_q && in_s;

  // ==========================================================
  // manual start arming
  // new press needed after supply return
  // limitation: a pulse cut short by a wiring change may arm once
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      armed_q <= 1'b0;
    end else if ((state_q != sosc_pkg::ST_RUN_DEEN) || !supply_s) begin
      armed_q <= 1'b0;
    end else if (!in_s && !win_act_q) begin
      // a release outside the window is a real release
      armed_q <= 1'b1;
    end
  end

  // no start without condition
  // the window masks the echo so it is not taken for a press
  assign start_ok = auto_s || (armed_q && in_s && !win_act_q);

  // ==========================================================
  // operating state machine
  // five operating states
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      sosc_pkg::ST_OFF: begin
        if (pg_s) begin
          state_d = sosc_pkg::ST_INIT;
        end
      end
      sosc_pkg::ST_INIT: begin
        if (stfail_s) begin
          state_d = sosc_pkg::ST_ERROR;
        end else if (init_cnt_q == INIT_LAST) begin
          state_d = sosc_pkg::ST_RUN_DEEN;
        end
      end
      sosc_pkg::ST_RUN_DEEN: begin
        if (echo_miss) begin
          state_d = sosc_pkg::ST_ERROR;
        end else if (supply_s && start_ok) begin
          state_d = sosc_pkg::ST_RUN_EN;
        end
      end
      sosc_pkg::ST_RUN_EN: begin
        if (echo_miss) begin
          state_d = sosc_pkg::ST_ERROR;
        end else if (!supply_s) begin
          state_d = sosc_pkg::ST_RUN_DEEN;
        end
      end
      sosc_pkg::ST_ERROR: begin
        // only a power cycle leaves error
        state_d = sosc_pkg::ST_ERROR;
      end
      default: begin
        // an illegal code is treated as a detected error
        state_d = sosc_pkg::ST_ERROR;
      end
    endcase
    if (!pg_s) begin
      state_d = sosc_pkg::ST_OFF;
    end
  end

  // state register
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      state_q <= sosc_pkg::ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // energized, safe and error outputs, registered from the next state to stay in step
  // only run-energized leaves safe state
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      en_q   <= 1'b0;
      safe_q <= 1'b1;
      err_q  <= 1'b0;
    end else begin
      en_q   <= (state_d == sosc_pkg::ST_RUN_EN);
      safe_q <= (state_d != sosc_pkg::ST_RUN_EN);
      err_q  <= (state_d == sosc_pkg::ST_ERROR);
    end
  end

  assign START_CONTROL_OUTPUT = ctl_q;
  assign OUTPUTS_ENERGIZED    = en_q;
  assign SAFE_STATE           = safe_q;
  assign ERROR_FLAG           = err_q;

  // ==========================================================
  // assertions and covers
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);

  energize_only_run_a: assert property (
    OUTPUTS_ENERGIZED |-> (state_q == sosc_pkg::ST_RUN_EN))
    else $error("outputs energized outside run state");

  safe_vs_energized_a: assert property (
    SAFE_STATE != OUTPUTS_ENERGIZED)
    else $error("safe state flag disagrees with outputs");

  power_on_init_a: assert property (
    ((state_q == sosc_pkg::ST_OFF) && pg_s) |=>
      (state_q == sosc_pkg::ST_INIT))
    else $error("power on did not start initialization");

  start_needs_supply_a: assert property (
    $rose(OUTPUTS_ENERGIZED) |-> $past(supply_s))
    else $error("outputs energized without supply");

  supply_loss_off_a: assert property (
    ((state_q == sosc_pkg::ST_RUN_EN) && !supply_s) |=>
      !OUTPUTS_ENERGIZED)
    else $error("supply loss left outputs energized");

  no_pulse_idle_a: assert property (
    !pulse_en |=> START_CONTROL_OUTPUT)
    else $error("test pulse while pulsing disabled");

  echo_miss_err_a: assert property (
    (echo_miss && pg_s) |=> ERROR_FLAG)
    else $error("missing echo did not raise error");

  error_sticky_a: assert property (
    ((state_q == sosc_pkg::ST_ERROR) && pg_s) |=>
      (state_q == sosc_pkg::ST_ERROR))
    else $error("error state left without power cycle");

  energized_c: cover property (state_q == sosc_pkg::ST_RUN_EN);
  pulse_fall_c: cover property ($fell(START_CONTROL_OUTPUT));
  echo_miss_c: cover property (echo_miss);
  init_fail_c: cover property (
    (state_q == sosc_pkg::ST_INIT) ##1 (state_q == sosc_pkg::ST_ERROR));

endmodule : sosc_top

// *** sosc_btn.sv ***
`timescale 1ns/100ps
// ==========================================================
// start/restart wiring: the control output reaches the input
// through the button or jumper; a cross circuit holds it high
module sosc_btn (
  // control output from the device
  input  wire logic ctl,
  // contact closed (button pressed or jumper fitted)
  input  wire logic closed,
  // injected cross circuit to the supply
  input  wire logic short_hi,
  // level seen on the input channel
  output logic      echo
);
  // an open contact reads low through the input pull-down
  // echo path of test pulses
  assign echo = (closed & ctl) | short_hi;
endmodule : sosc_btn

// *** safety_output_state_control_tb_top.sv ***
`timescale 1ns/100ps
module safety_output_state_control_tb_top;
  // ==========================================================
  // short pulse timing keeps the run brief
  localparam int TB_WIDTH  = 4;
  localparam int TB_PERIOD = 40;
  localparam int TB_ECHO   = 8;
  localparam int TB_INIT   = sosc_pkg::INIT_CYC;
  // clock, reset and stimulus
  logic c        = 1'b0;
  logic r        = 1'b1;
  logic pg       = 1'b1;
  logic sp       = 1'b1;
  logic closed   = 1'b1;
  logic short_hi = 1'b0;
  logic au       = 1'b1;
  logic dyn      = 1'b1;
  logic stf      = 1'b0;
  // partner and design outputs
  logic ec;
  logic y;
  logic en;
  logic sf;
  logic er;
  int   errors   = 0;
  int   compares = 0;
  int   seed     = 32'h3C874B85;
  int   rnd;
  int   lows;
  initial begin
    forever #50 c = ~c;
  end
  sosc_btn b (.ctl(y), .closed(closed), .short_hi(short_hi), .echo(ec));
  sosc_top #(.PULSE_WIDTH_CYC(TB_WIDTH), .PULSE_PERIOD_CYC(TB_PERIOD),
    .ECHO_DELAY_CYC(TB_ECHO)) dut (.SYS_CLK(c), .SRST(r),
    .POWER_GOOD(pg), .SUPPLY_IN(sp), .START_AUTO_MANUAL_INPUT(ec),
    .AUTO_START(au), .DYN_WIRED(dyn), .SELF_TEST_FAIL(stf),
    .START_CONTROL_OUTPUT(y), .OUTPUTS_ENERGIZED(en), .SAFE_STATE(sf),
    .ERROR_FLAG(er));
  // expected pulse low cycles in one period
  function automatic int exp_lows(input logic dyn_on);
    return dyn_on ? TB_WIDTH : 0;
  endfunction : exp_lows
  // cycles to wait for power-up, self-test and start
  function automatic int init_wait(input int extra);
    return TB_INIT + 20 + extra;
  endfunction : init_wait
  task chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("Error %s expected %0d seen %0d", n, e, s);
    end
  endtask : chk
  // sample where outputs have settled
  task look;
    @(negedge c);
  endtask : look
  // count control output lows over one pulse period
  task automatic count_lows(output int n);
    n = 0;
    repeat (TB_PERIOD) begin
      @(negedge c);
      if (y === 1'b0) n++;
    end
  endtask : count_lows
  task report_and_stop;
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task w(int n); repeat (n) @(posedge c); endtask : w
  initial begin
    w(5);
    r <= 1'b0;
    w(500);
    look;
    chk("en", en, 0);
    chk("safe", sf, 1);
    w(init_wait({$random(seed)} % 9));
    look;
    chk("en", en, 1);
    chk("safe", sf, 0);
    w(1);
    count_lows(lows);
    chk("lows", lows, exp_lows(1'b1));
    count_lows(lows);
    chk("lows", lows, exp_lows(1'b1));
    chk("err", er, 0);
    w(1);
    sp <= 1'b0;
    w(5);
    look;
    chk("en", en, 0);
    chk("safe", sf, 1);
    w(1);
    au <= 1'b0;
    sp <= 1'b1;
    w(40);
    look;
    chk("en", en, 0);
    w(1);
    closed <= 1'b0;
    w(20);
    look;
    chk("en", en, 0);
    w(1);
    closed <= 1'b1;
    w(20);
    look;
    chk("en", en, 1);
    chk("safe", sf, 0);
    w(1);
    au <= 1'b1;
    short_hi <= 1'b1;
    w(TB_PERIOD + 20);
    look;
    chk("err", er, 1);
    chk("en", en, 0);
    repeat (30) begin
      w(1);
      rnd = $random(seed);
      closed <= rnd[0];
      au <= rnd[1];
      sp <= rnd[2];
      short_hi <= rnd[3];
    end
    w(1);
    closed <= 1'b1;
    au <= 1'b1;
    sp <= 1'b1;
    short_hi <= 1'b0;
    w(TB_PERIOD);
    look;
    chk("err", er, 1);
    chk("en", en, 0);
    w(1);
    pg <= 1'b0;
    w(5);
    look;
    chk("err", er, 0);
    chk("safe", sf, 1);
    w(1);
    stf <= 1'b1;
    pg <= 1'b1;
    w(20);
    look;
    chk("err", er, 1);
    w(1);
    stf <= 1'b0;
    pg <= 1'b0;
    w(5);
    pg <= 1'b1;
    w(init_wait({$random(seed)} % 9));
    look;
    chk("en", en, 1);
    w(1);
    dyn <= 1'b0;
    w(5);
    count_lows(lows);
    chk("lows", lows, exp_lows(1'b0));
    w(1);
    short_hi <= 1'b1;
    w(TB_PERIOD + 20);
    look;
    chk("err", er, 0);
    chk("en", en, 1);
    w(1);
    short_hi <= 1'b0;
    dyn <= 1'b1;
    w(5);
    count_lows(lows);
    chk("lows", lows, exp_lows(1'b1));
    chk("err", er, 0);
    w(1);
    r <= 1'b1;
    w(5);
    look;
    chk("en", en, 0);
    chk("err", er, 0);
    w(1);
    r <= 1'b0;
    w(2);
    look;
    chk("en", en, 0);
    chk("ctl", y, 1);
    w(init_wait(0));
    look;
    chk("en", en, 1);
    report_and_stop;
  end
  initial begin
    #1_000_000;
    errors++;
    report_and_stop;
  end
endmodule : safety_output_state_control_tb_top
